// File: design/rse_regs.sv
// repeater security, compression, gap and port event register bank
// Functional notes
// R1: with compression on, forward exactly compress length data bytes, up to 255
// R2: security bit 0 starts address comparison when one
// R3: security bit 1 zero makes random pattern on valid source mismatch
// R4: source address mismatch is always reported to hub management
// R5: security bit 2 one alters fifth status byte of management bytes
// R6: software keeps security bit 3 at zero; bit is reserved
// R7: security bit 4 one disables a port on valid source mismatch
// R8: security bit 6 enables learn on all ports; reads back written value
// R9: security bit 7 reads zero; bit 5 has no function
// R10: management bus gap at least threshold plus one bit times
// R11: one event record per port at 11h-1Dh page 1, cleared on read
// R12: record bits 0-4: jabber, elastic buffer, lock loss, no delimiter, short
// R13: record bits 5-7: late collision, partition, link failure
// R14: upper summary at 1Eh shows ports 1-8, bit n-1 for port n
// R15: an event is recorded only while its record enable bit is one
// R16: flag found mask zero drives event pin while any recorded flag is set
// R17: lower summary at 1Fh page 1 shows ports 9-13 likewise
// R18: summary bit set while port record nonzero, clears when read empties it
//
// Implementation choice: the plain strobed port.
`default_nettype none
module rse_regs #(
    parameter int NPORT      = rse_pkg::NPORT,
    parameter int BIT_CYCLES = rse_pkg::BIT_CYCLES
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic [4:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output var  logic [7:0]           reg_rdata,
    input  wire logic                 compress_sel,
    input  wire logic                 frame_start,
    input  wire logic                 data_byte_stb,
    output var  logic                 compress_pass,
    input  wire logic                 mgmt_pkt_end,
    output var  logic                 mgmt_gap_ok,
    input  wire logic                 sa_mismatch,
    input  wire logic [3:0]           sa_mismatch_port,
    input  wire logic [NPORT*8-1:0]   port_events,
    output var  logic                 compare_begin,
    output var  logic                 scramble_pkt,
    output var  logic                 sa_mismatch_report,
    output var  logic                 alter_status_byte,
    output var  logic                 all_ports_learn,
    output var  logic [NPORT-1:0]     port_off,
    output var  logic                 event_log_irq_pin,
    output var  logic                 irq
);

    // ----------------------------------------
    // register state
    // ----------------------------------------
    logic [3:0]         page_r;
    logic [7:0]         comp_len_r;
    logic [7:0]         gsr_r;
    logic [7:0]         gap_thr_r;
    logic [7:0]         rec_en_r;
    logic [7:0]         irq_cfg_r;
    logic [7:0]         irq_stat_r;
    logic [7:0]         irq_mask_r;
    logic [7:0]         rec_r [NPORT];
    logic [NPORT-1:0]   summary;
    logic [NPORT-1:0]   off_latch_r;
    logic [7:0]         sent_cnt_r;
    logic [7:0]         rd_mux;
    logic               any_flag;
    logic               any_flag_d_r;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic logic hit(input logic [3:0] pg, input logic [4:0] off,
                                 input logic [3:0] cur, input logic [4:0] addr);
        hit = (cur == pg) && (addr == off);
    endfunction

    function automatic logic rec_hit(input logic [3:0] cur, input logic [4:0] addr,
                                     input int idx);
        rec_hit = (cur == rse_pkg::PAGE_EVT)
               && (addr == rse_pkg::OFF_REC_FIRST + 5'(idx));
    endfunction

    // ----------------------------------------
    // page select and configuration writes
    // ----------------------------------------
    // page select answers on every page so software can always leave a page
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            page_r <= rse_pkg::RST_PAGE;
        end else if (reg_wr && reg_addr == rse_pkg::OFF_PAGE_SEL) begin
            page_r <= reg_wdata[3:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            comp_len_r <= rse_pkg::RST_COMP_LEN;
            gap_thr_r  <= rse_pkg::RST_GAP_THR;
            rec_en_r   <= rse_pkg::RST_REC_EN;
            irq_cfg_r  <= rse_pkg::RST_IRQ_CFG;
            irq_mask_r <= rse_pkg::RST_IRQ_MASK;
        end else if (reg_wr) begin
            if (hit(rse_pkg::PAGE_CFG, rse_pkg::OFF_COMP_LEN, page_r, reg_addr)) begin
                comp_len_r <= reg_wdata;
            end
            if (hit(rse_pkg::PAGE_CFG, rse_pkg::OFF_GAP_THR, page_r, reg_addr)) begin
                gap_thr_r <= reg_wdata;
            end
            if (hit(rse_pkg::PAGE_CFG, rse_pkg::OFF_REC_EN, page_r, reg_addr)) begin
                rec_en_r <= reg_wdata;
            end
            if (hit(rse_pkg::PAGE_CFG, rse_pkg::OFF_IRQ_CFG, page_r, reg_addr)) begin
                irq_cfg_r <= reg_wdata;
            end
            if (hit(rse_pkg::PAGE_CFG, rse_pkg::OFF_IRQ_MASK, page_r, reg_addr)) begin
                irq_mask_r <= reg_wdata & rse_pkg::IST_WR_MASK;
            end
        end
    end

    // ----------------------------------------
    // global security register
    // ----------------------------------------
    // R9: reserved bits masked
    // reserved bits 3, 5 and 7 never store, so they read back zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gsr_r <= rse_pkg::RST_GSR;
        end else if (reg_wr && hit(rse_pkg::PAGE_CFG, rse_pkg::OFF_GSR, page_r, reg_addr)) begin
            gsr_r <= reg_wdata & rse_pkg::GSR_WR_MASK;
        end
    end

    // R2: comparison start
    assign compare_begin     = gsr_r[rse_pkg::GSR_COMPARE];
    // R5: status byte alter
    assign alter_status_byte = gsr_r[rse_pkg::GSR_ALTER];
    // R8: learn on all
    assign all_ports_learn   = gsr_r[rse_pkg::GSR_LEARN];

    // ----------------------------------------
    // source address mismatch handling
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            scramble_pkt       <= 1'b0;
            sa_mismatch_report <= 1'b0;
        end else begin
            // R3: random pattern select
            scramble_pkt       <= sa_mismatch && !gsr_r[rse_pkg::GSR_SCRAMBLE];
            // R4: report regardless
            sa_mismatch_report <= sa_mismatch;
        end
    end

    // R7: port disable
    // the disable holds until software turns the feature off again
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            off_latch_r <= '0;
        end else if (!gsr_r[rse_pkg::GSR_PORT_OFF]) begin
            off_latch_r <= '0;
        end else if (sa_mismatch && sa_mismatch_port < 4'(NPORT)) begin
            off_latch_r[sa_mismatch_port] <= 1'b1;
        end
    end

    assign port_off = off_latch_r;

    // ----------------------------------------
    // packet compression byte count
    // ----------------------------------------
    // R1: exact byte count
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sent_cnt_r    <= '0;
            compress_pass <= 1'b1;
        end else if (frame_start) begin
            sent_cnt_r    <= '0;
            compress_pass <= !compress_sel || (comp_len_r != 8'h00);
        end else if (data_byte_stb && compress_pass) begin
            if (sent_cnt_r != 8'hFF) begin
                sent_cnt_r <= sent_cnt_r + 8'h01;
            end
            compress_pass <= !compress_sel || (sent_cnt_r + 8'h01 < comp_len_r);
        end
    end

    // ----------------------------------------
    // management bus gap
    // ----------------------------------------
    rse_gap_timer #(
        .BIT_CYCLES (BIT_CYCLES)
    ) u_gap (
        .clk_sys       (clk_sys),
        .rst_n         (rst_n),
        .gap_threshold (gap_thr_r),
        .pkt_end       (mgmt_pkt_end),
        .gap_ok        (mgmt_gap_ok)
    );

    // ----------------------------------------
    // port event records
    // ----------------------------------------
    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_port
            logic [7:0] ev_in;
            assign ev_in = port_events[p*8 +: 8] & rec_en_r;

            // R11: clear on read
            // R12: low event bits
            // R13: high event bits
            // R15: enable gating
            // an event landing with the clearing read survives it
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    rec_r[p] <= '0;
                end else if (reg_rd && rec_hit(page_r, reg_addr, p)) begin
                    rec_r[p] <= ev_in;
                end else begin
                    rec_r[p] <= rec_r[p] | ev_in;
                end
            end

            // R18: summary tracks record
            assign summary[p] = |rec_r[p];
        end
    endgenerate

    assign any_flag = |summary;

    // ----------------------------------------
    // event pin and interrupt
    // ----------------------------------------
    // R16: flag found pin
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            event_log_irq_pin <= 1'b0;
        end else begin
            event_log_irq_pin <= any_flag && !irq_cfg_r[rse_pkg::IRQ_CFG_FF_MSK];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            any_flag_d_r <= 1'b0;
        end else begin
            any_flag_d_r <= any_flag;
        end
    end

    // write one clears, but a new event in the same cycle wins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r
                        & ~((reg_wr && hit(rse_pkg::PAGE_CFG, rse_pkg::OFF_IRQ_STAT,
                                           page_r, reg_addr)) ? reg_wdata : 8'h00))
                        | {6'h00, sa_mismatch, any_flag && !any_flag_d_r};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr == rse_pkg::OFF_PAGE_SEL) begin
            rd_mux = {4'h0, page_r};
        end else if (page_r == rse_pkg::PAGE_CFG) begin
            unique case (reg_addr)
                rse_pkg::OFF_COMP_LEN: rd_mux = comp_len_r;
                // R8: written value
                rse_pkg::OFF_GSR:      rd_mux = gsr_r;
                rse_pkg::OFF_GAP_THR:  rd_mux = gap_thr_r;
                rse_pkg::OFF_REC_EN:   rd_mux = rec_en_r;
                rse_pkg::OFF_IRQ_CFG:  rd_mux = irq_cfg_r;
                rse_pkg::OFF_IRQ_STAT: rd_mux = irq_stat_r;
                rse_pkg::OFF_IRQ_MASK: rd_mux = irq_mask_r;
                default:               rd_mux = 8'h00;
            endcase
        end else if (page_r == rse_pkg::PAGE_EVT) begin
            if (reg_addr >= rse_pkg::OFF_REC_FIRST && reg_addr <= rse_pkg::OFF_REC_LAST) begin
                rd_mux = rec_r[4'(reg_addr - rse_pkg::OFF_REC_FIRST)];
            // R14: ports 1 to 8
            end else if (reg_addr == rse_pkg::OFF_SUM_UPPER) begin
                rd_mux = summary[7:0];
            // R17: ports 9 to 13
            end else if (reg_addr == rse_pkg::OFF_SUM_LOWER) begin
                rd_mux = {3'h0, summary[NPORT-1:8]};
            end
        end
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule
`default_nettype wire

// File: common/rse_pkg.sv
// constants for the repeater security and event register bank
`default_nettype none
package rse_pkg;
    localparam int          ADDR_W         = 5;
    localparam int          PAGE_W         = 4;
    localparam int          NPORT          = 13;
    localparam int          NEVT           = 8;

    // pages
    localparam logic [3:0]  PAGE_CFG       = 4'h0;
    localparam logic [3:0]  PAGE_EVT       = 4'h1;

    // offsets present on every page
    localparam logic [4:0]  OFF_PAGE_SEL   = 5'h10;
    // page 0 offsets
    localparam logic [4:0]  OFF_REC_EN     = 5'h14;
    localparam logic [4:0]  OFF_IRQ_CFG    = 5'h16;
    localparam logic [4:0]  OFF_COMP_LEN   = 5'h18;
    localparam logic [4:0]  OFF_IRQ_STAT   = 5'h1A;
    localparam logic [4:0]  OFF_IRQ_MASK   = 5'h1B;
    localparam logic [4:0]  OFF_GSR        = 5'h1D;
    localparam logic [4:0]  OFF_GAP_THR    = 5'h1F;
    // page 1 offsets
    localparam logic [4:0]  OFF_REC_FIRST  = 5'h11;
    localparam logic [4:0]  OFF_REC_LAST   = 5'h1D;
    localparam logic [4:0]  OFF_SUM_UPPER  = 5'h1E;
    localparam logic [4:0]  OFF_SUM_LOWER  = 5'h1F;

    // global security fields
    localparam int          GSR_COMPARE    = 0;
    localparam int          GSR_SCRAMBLE   = 1;
    localparam int          GSR_ALTER      = 2;
    localparam int          GSR_PORT_OFF   = 4;
    localparam int          GSR_LEARN      = 6;
    localparam logic [7:0]  GSR_WR_MASK    = 8'h57;

    // interrupt configuration fields
    localparam int          IRQ_CFG_FF_MSK = 4;

    // interrupt status fields
    localparam int          IST_FLAG_FOUND = 0;
    localparam int          IST_SA_MISS    = 1;
    localparam logic [7:0]  IST_WR_MASK    = 8'h03;

    // reset values
    localparam logic [7:0]  RST_COMP_LEN   = 8'h00;
    localparam logic [7:0]  RST_GSR        = 8'h00;
    localparam logic [7:0]  RST_GAP_THR    = 8'h00;
    localparam logic [7:0]  RST_REC_EN     = 8'h00;
    localparam logic [7:0]  RST_IRQ_CFG    = 8'hFF;
    localparam logic [7:0]  RST_IRQ_MASK   = 8'h00;
    localparam logic [3:0]  RST_PAGE       = 4'h0;

    // timing
    localparam int          CLK_PERIOD_NS  = 25;
    localparam int          BIT_TIME_NS    = 100;
    localparam int          BIT_CYCLES     = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// File: design/rse_gap_timer.sv
// minimum inter-frame gap timer for the management bus
`default_nettype none
module rse_gap_timer #(
    parameter int BIT_CYCLES = rse_pkg::BIT_CYCLES
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic [7:0] gap_threshold,
    input  wire logic       pkt_end,
    output var  logic       gap_ok
);
    localparam int DIV_W = (BIT_CYCLES > 1) ? $clog2(BIT_CYCLES) : 1;

    logic [DIV_W-1:0] div_r;
    logic             bit_tick;
    logic [8:0]       left_r;

    // ----------------------------------------
    // bit-time enable
    // ----------------------------------------
    // divider restarts at packet end so every counted bit time is whole
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= '0;
        end else if (pkt_end || div_r == DIV_W'(BIT_CYCLES - 1)) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    assign bit_tick = (div_r == DIV_W'(BIT_CYCLES - 1));

    // ----------------------------------------
    // gap count
    // ----------------------------------------
    // R10: gap of threshold plus one
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            left_r <= '0;
            gap_ok <= 1'b1;
        end else if (pkt_end) begin
            left_r <= {1'b0, gap_threshold} + 9'h001;
            gap_ok <= 1'b0;
        end else if (bit_tick && left_r != 9'h000) begin
            left_r <= left_r - 9'h001;
            gap_ok <= (left_r == 9'h001);
        end
    end
endmodule
`default_nettype wire

// File: verification/rse_regs_monitor.sv
// assertion checker for the security and event register bank
`default_nettype none
module rse_regs_monitor #(
    parameter int NPORT      = 13,
    parameter int BIT_CYCLES = 4
) (
    input wire logic             clk_sys,
    input wire logic             rst_n,
    input wire logic [4:0]       reg_addr,
    input wire logic [7:0]       reg_wdata,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [7:0]       reg_rdata,
    input wire logic             compress_sel,
    input wire logic             frame_start,
    input wire logic             data_byte_stb,
    input wire logic             compress_pass,
    input wire logic             mgmt_pkt_end,
    input wire logic             mgmt_gap_ok,
    input wire logic             sa_mismatch,
    input wire logic [3:0]       sa_mismatch_port,
    input wire logic             compare_begin,
    input wire logic             scramble_pkt,
    input wire logic             sa_mismatch_report,
    input wire logic             alter_status_byte,
    input wire logic             all_ports_learn,
    input wire logic [NPORT-1:0] port_off
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [15:0] gap_cnt;
    logic [7:0]  wd_q;
    logic        wr_gsr_q;
    // saturating cycle count since packet end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) gap_cnt <= 16'hFFFF;
        else if (mgmt_pkt_end) gap_cnt <= 16'h0000;
        else if (gap_cnt != 16'hFFFF) gap_cnt <= gap_cnt + 16'h0001;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) wr_gsr_q <= 1'b0;
        else wr_gsr_q <= reg_wr && (reg_addr == rse_pkg::OFF_GSR);
    end
    always_ff @(posedge clk_sys) begin
        wd_q <= reg_wdata;
    end
    sequence s_end; mgmt_pkt_end; endsequence
    sequence s_hold; !mgmt_gap_ok; endsequence
    property p_gap_low; s_end |=> s_hold; endproperty
    a_gap_low: assert property (p_gap_low)
        else $error("gap flag not low after packet end");
    property p_gap_len; $rose(mgmt_gap_ok) |-> gap_cnt >= BIT_CYCLES - 1; endproperty
    a_gap_len: assert property (p_gap_len)
        else $error("gap flag returned too early");
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside read answer");
    property p_scr; scramble_pkt |-> $past(sa_mismatch); endproperty
    a_scr: assert property (p_scr)
        else $error("scramble without mismatch");
    property p_rep; sa_mismatch |=> sa_mismatch_report; endproperty
    a_rep: assert property (p_rep)
        else $error("mismatch not reported");
    property p_off;
        (port_off & ~$past(port_off)) != '0 |-> $past(sa_mismatch) &&
            (port_off & ~$past(port_off)) == (NPORT'(1) << $past(sa_mismatch_port));
    endproperty
    a_off: assert property (p_off)
        else $error("port disabled without matching mismatch");
    property p_pass_fall;
        $fell(compress_pass) |-> ($past(data_byte_stb) || $past(frame_start)) && $past(compress_sel);
    endproperty
    a_pass_fall: assert property (p_pass_fall)
        else $error("compress pass fell without cause");
    property p_pass_rise; $rose(compress_pass) |-> $past(frame_start); endproperty
    a_pass_rise: assert property (p_pass_rise)
        else $error("compress pass rose without frame start");
    property p_gsr;
        $changed({all_ports_learn, alter_status_byte, compare_begin}) |-> wr_gsr_q &&
            {all_ports_learn, alter_status_byte, compare_begin} == {wd_q[6], wd_q[2], wd_q[0]};
    endproperty
    a_gsr: assert property (p_gsr)
        else $error("security levels changed without write");
endmodule
bind rse_regs rse_regs_monitor #(.NPORT(NPORT), .BIT_CYCLES(BIT_CYCLES)) rse_regs_monitor_inst (.*);
`default_nettype wire

// File: verification/rse_host_model.sv
// host processor model driving the paged register port
`default_nettype none
module rse_host_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] reg_rdata,
    output var  logic [4:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr  = 5'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask
    // data stand one cycle after the strobe; sample just past that edge
    task automatic rd(input logic [4:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask
endmodule
`default_nettype wire

// File: verification/rse_regs_tb_top.sv
// self-checking bench for the security and event register bank
`default_nettype none
module rse_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NP = 13;
    localparam int BC = 4;
    localparam logic [4:0] RA [8] = '{5'h14, 5'h16, 5'h18, 5'h1A, 5'h1B, 5'h1D, 5'h1F, 5'h12};
    localparam logic [7:0] RV [8] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic clk_sys = 1'b0, rst_n = 1'b0;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, m, d;
    logic reg_wr, reg_rd, compress_pass, mgmt_gap_ok, compare_begin, scramble_pkt;
    logic sa_mismatch_report, alter_status_byte, all_ports_learn, event_log_irq_pin, irq;
    logic compress_sel = 1'b0, frame_start = 1'b0, data_byte_stb = 1'b0;
    logic mgmt_pkt_end = 1'b0, sa_mismatch = 1'b0;
    logic [3:0] sa_mismatch_port = 4'h0;
    logic [NP*8-1:0] port_events = '0;
    logic [NP-1:0] port_off;
    int fails = 0, checked = 0, n, p;
    always #12.5 clk_sys = ~clk_sys;
    rse_regs #(.NPORT(NP), .BIT_CYCLES(BC)) rse_regs_inst (.*);
    rse_host_model host (.*);
    // ----------------------------------------------------------------
    // tasks and expectations
    // ----------------------------------------------------------------
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic rc(input string s, input logic [4:0] a, input logic [7:0] e);
        logic [7:0] g;
        host.rd(a, g);
        chk(s, 16'(e), 16'(g));
    endtask
    // one-cycle pulse: 0 frame, 1 byte, 2 packet end, 3 mismatch, 4+ port event bit
    task automatic pl(input int k);
        @(posedge clk_sys);
        case (k)
            0: frame_start <= 1'b1;
            1: data_byte_stb <= 1'b1;
            2: mgmt_pkt_end <= 1'b1;
            3: sa_mismatch <= 1'b1;
            default: port_events[k-4] <= 1'b1;
        endcase
        @(posedge clk_sys);
        {frame_start, data_byte_stb, mgmt_pkt_end, sa_mismatch} <= 4'h0;
        port_events <= '0;
    endtask
    function automatic logic [7:0] gsr_exp(input logic [7:0] v);
        return {1'b0, v[6], 1'b0, v[4], 1'b0, v[2:0]};
    endfunction
    function automatic logic [7:0] sum_exp(input int q, input int lo, input logic en);
        return (en && q >= lo && q < lo + 8) ? 8'(1 << (q - lo)) : 8'h00;
    endfunction
    initial begin
        #2000000;
        fails++;
        finish_test();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'hcf77));
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1 chk("pass_reset", 1, compress_pass);
        chk("gap_reset", 1, mgmt_gap_ok);
        for (int i = 0; i < 8; i++) rc("reset_value", RA[i], RV[i]);
        for (int i = 0; i < 5; i++) begin
            d = (i == 0) ? 8'hFF : 8'($urandom);
            d[3] = 1'b0;
            host.wr(rse_pkg::OFF_GSR, d);
            rc("gsr", rse_pkg::OFF_GSR, gsr_exp(d));
            chk("gsr_levels", 16'({d[6], d[2], d[0]}),
                16'({all_ports_learn, alter_status_byte, compare_begin}));
        end
        compress_sel <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            m = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'hFF : 8'($urandom_range(2, 40));
            if (i == 4) compress_sel <= 1'b0;
            host.wr(rse_pkg::OFF_COMP_LEN, m);
            pl(0);
            n = 0;
            repeat (int'(m) + 3) begin
                #1 n += int'(compress_pass);
                pl(1);
            end
            chk("comp_bytes", (i == 4) ? 16'(m) + 16'h0003 : 16'(m), 16'(n));
        end
        for (int i = 0; i < 3; i++) begin
            m = (i == 0) ? 8'h00 : 8'($urandom_range(1, 6));
            host.wr(rse_pkg::OFF_GAP_THR, m);
            pl(2);
            n = 0;
            #1;
            while (mgmt_gap_ok !== 1'b1 && n < 2000) begin
                @(posedge clk_sys);
                #1 n++;
            end
            chk("gap_min", 1, 16'(n >= (m + 1) * BC && n <= (m + 1) * BC + 1));
        end
        host.wr(rse_pkg::OFF_IRQ_STAT, 8'h03);
        host.wr(rse_pkg::OFF_IRQ_MASK, 8'h02);
        host.wr(rse_pkg::OFF_GSR, 8'h10);
        p = $urandom_range(0, 12);
        sa_mismatch_port <= 4'(p);
        pl(3);
        #1 chk("scramble", 1, 16'(scramble_pkt));
        chk("report", 1, 16'(sa_mismatch_report));
        chk("port_off", 16'(1) << p, 16'(port_off));
        @(posedge clk_sys);
        #1 chk("irq_on", 1, 16'(irq));
        host.wr(rse_pkg::OFF_IRQ_MASK, 8'h00);
        @(posedge clk_sys);
        #1 chk("irq_masked", 0, 16'(irq));
        rc("irq_stat", rse_pkg::OFF_IRQ_STAT, 8'h02);
        host.wr(rse_pkg::OFF_IRQ_STAT, 8'h02);
        host.wr(rse_pkg::OFF_GSR, 8'h02);
        rc("irq_cleared", rse_pkg::OFF_IRQ_STAT, 8'h00);
        chk("port_on", 0, 16'(port_off));
        host.wr(rse_pkg::OFF_GSR, 8'h12);
        sa_mismatch_port <= 4'hD;
        pl(3);
        #1 chk("no_scramble", 0, 16'(scramble_pkt));
        chk("report2", 1, 16'(sa_mismatch_report));
        chk("port_range", 0, 16'(port_off));
        m = 8'($urandom);
        m[0] = 1'b1;
        m[1] = 1'b0;
        host.wr(rse_pkg::OFF_REC_EN, m);
        host.wr(rse_pkg::OFF_IRQ_CFG, 8'hEF);
        host.wr(rse_pkg::OFF_PAGE_SEL, 8'h01);
        for (int b = 0; b < 8; b++) begin
            p = (b == 0) ? 12 : (b == 1) ? 0 : $urandom_range(0, 12);
            pl(4 + p * 8 + b);
            @(posedge clk_sys);
            #1 chk("event_pin", 16'(m[b]), 16'(event_log_irq_pin));
            rc("sum_upper", rse_pkg::OFF_SUM_UPPER, sum_exp(p, 0, m[b]));
            rc("sum_lower", rse_pkg::OFF_SUM_LOWER, sum_exp(p, 8, m[b]));
            rc("record", 5'(17 + p), m[b] ? 8'(1 << b) : 8'h00);
            rc("record_again", 5'(17 + p), 8'h00);
            rc("sum_after", (p < 8) ? 5'h1E : 5'h1F, 8'h00);
            chk("pin_after", 0, 16'(event_log_irq_pin));
        end
        host.wr(rse_pkg::OFF_PAGE_SEL, 8'h00);
        rc("flag_stat", rse_pkg::OFF_IRQ_STAT, 8'h03);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rc("gsr_reset", rse_pkg::OFF_GSR, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
